// ===== ccs_pkg.sv
// constants, field layout and state record for the codec clock source select block
// assumes one register port driven by the control-bus slave on the same clock
package ccs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CCS_SRC_SEL_ADDR = 8'h65;
  localparam logic [7:0] CCS_GEN_CTL_ADDR = 8'h66;
  localparam logic [7:0] CCS_SRC_SEL_RST = 8'h00;
  localparam logic [7:0] CCS_GEN_CTL_RST = 8'h02;
  localparam logic [7:0] CCS_RDATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CCS_CORE_SEL_BIT = 0;
  localparam int CCS_DIV_SRC_HI = 7;
  localparam int CCS_DIV_SRC_LO = 6;
  localparam int CCS_REF_SRC_HI = 5;
  localparam int CCS_REF_SRC_LO = 4;
  localparam int CCS_NDIV_HI = 3;
  localparam int CCS_NDIV_LO = 0;
  // source code 10 picks the bit clock, 00 the master clock
  localparam int CCS_SRC_BCLK_BIT = 1;

  // ----------------------------------------------------------------
  // divider encoding
  // ----------------------------------------------------------------
  localparam logic [3:0] CCS_NCODE_16 = 4'h0;
  localparam logic [3:0] CCS_NCODE_17 = 4'h1;
  localparam logic [4:0] CCS_NVAL_16 = 5'h10;
  localparam logic [4:0] CCS_NVAL_17 = 5'h11;
  localparam logic [4:0] CCS_CNT_ZERO = 5'h00;
  localparam logic [4:0] CCS_CNT_ONE = 5'h01;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccs_reg_req_t;

  typedef struct packed {
    logic [1:0] mpin_sync;
    logic [1:0] bpin_sync;
    logic [1:0] pll_sync;
    logic [1:0] cdo_sync;
    logic pll_prev;
    logic core_sel;
    logic [7:0] gen_ctl;
    logic [4:0] cnt;
    logic pdo;
    logic core_clk;
    logic div_in;
    logic ref_in;
    logic [7:0] rdata;
  } ccs_state_t;

  function automatic logic [4:0] ccs_nval(input logic [3:0] code);
    if (code == CCS_NCODE_16)
      return CCS_NVAL_16;
    else if (code == CCS_NCODE_17)
      return CCS_NVAL_17;
    else
      return {1'b0, code};
  endfunction : ccs_nval

endpackage : ccs_pkg

// ===== ccs_clock_select.sv
// clock source multiplexers and pll divider with their two control registers
// assumes pins and pll clock are far slower than mclk, so sampling them is enough
`timescale 1ns/100ps

module ccs_clock_select
  import ccs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input ccs_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic master_clk_pin,
  input wire logic bit_clk_pin,
  input wire logic pll_clock,
  input wire logic clock_divider_output,
  output logic clock_divider_input,
  output logic pll_reference_input,
  output logic pll_divider_output,
  output logic codec_core_clock
);

  ccs_state_t s_r;
  ccs_state_t s_nxt;
  logic [4:0] nval;
  logic pll_rise;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    nval = ccs_nval(s_r.gen_ctl[CCS_NDIV_HI:CCS_NDIV_LO]);
    s_nxt.mpin_sync = {s_r.mpin_sync[0], master_clk_pin};
    s_nxt.bpin_sync = {s_r.bpin_sync[0], bit_clk_pin};
    s_nxt.pll_sync = {s_r.pll_sync[0], pll_clock};
    s_nxt.cdo_sync = {s_r.cdo_sync[0], clock_divider_output};
    s_nxt.pll_prev = s_r.pll_sync[1];
    pll_rise = s_r.pll_sync[1] && !s_r.pll_prev;

    // register writes; reserved select bits are simply not stored
    if (reg_req.wr && reg_req.addr == CCS_SRC_SEL_ADDR)
      s_nxt.core_sel = reg_req.wdata[CCS_CORE_SEL_BIT];
    if (reg_req.wr && reg_req.addr == CCS_GEN_CTL_ADDR)
      s_nxt.gen_ctl = reg_req.wdata;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        CCS_SRC_SEL_ADDR: s_nxt.rdata = {7'h00, s_r.core_sel};
        CCS_GEN_CTL_ADDR: s_nxt.rdata = s_r.gen_ctl;
        default: s_nxt.rdata = CCS_RDATA_RST;
      endcase
    end

    // reserved source codes fold onto their high bit
    s_nxt.div_in = s_r.gen_ctl[CCS_DIV_SRC_HI - 1 + CCS_SRC_BCLK_BIT] ?
      s_r.bpin_sync[1] : s_r.mpin_sync[1];
    s_nxt.ref_in = s_r.gen_ctl[CCS_REF_SRC_HI - 1 + CCS_SRC_BCLK_BIT] ?
      s_r.bpin_sync[1] : s_r.mpin_sync[1];

    // counting wraps at or past n-1 so a smaller new value is never overrun
    if (pll_rise)
    begin
      if (s_r.cnt >= nval - CCS_CNT_ONE)
        s_nxt.cnt = CCS_CNT_ZERO;
      else
        s_nxt.cnt = s_r.cnt + CCS_CNT_ONE;
    end
    if (s_r.cnt >= nval)
      s_nxt.cnt = CCS_CNT_ZERO;
    // high for the first half of each period; odd n gives a short high phase
    s_nxt.pdo = (s_nxt.cnt < (nval >> 1));

    s_nxt.core_clk = s_r.core_sel ? s_r.cdo_sync[1] : s_r.pdo;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.core_sel <= CCS_SRC_SEL_RST[CCS_CORE_SEL_BIT];
      s_r.gen_ctl <= CCS_GEN_CTL_RST;
      s_r.rdata <= CCS_RDATA_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign reg_rdata = s_r.rdata;
  assign clock_divider_input = s_r.div_in;
  assign pll_reference_input = s_r.ref_in;
  assign pll_divider_output = s_r.pdo;
  assign codec_core_clock = s_r.core_clk;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_core_mux;
    ##1 codec_core_clock == ($past(s_r.core_sel) ? $past(s_r.cdo_sync[1]) : $past(s_r.pdo));
  endproperty
  a_core_mux: assert property (p_core_mux) else $error("core clock mux wrong");

  property p_rsvd_zero;
    reg_req.rd && reg_req.addr == CCS_SRC_SEL_ADDR |=> reg_rdata[7:1] == 7'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

  property p_div_src;
    ##1 clock_divider_input == ($past(s_r.gen_ctl[CCS_DIV_SRC_HI]) ?
      $past(s_r.bpin_sync[1]) : $past(s_r.mpin_sync[1]));
  endproperty
  a_div_src: assert property (p_div_src) else $error("divider input source wrong");

  property p_ref_src;
    ##1 pll_reference_input == ($past(s_r.gen_ctl[CCS_REF_SRC_HI]) ?
      $past(s_r.bpin_sync[1]) : $past(s_r.mpin_sync[1]));
  endproperty
  a_ref_src: assert property (p_ref_src) else $error("pll reference source wrong");

  property p_cnt_range;
    s_r.cnt < ccs_nval($past(s_r.gen_ctl[CCS_NDIV_HI:CCS_NDIV_LO])) || $changed(s_r.gen_ctl)
      || s_r.cnt == CCS_CNT_ZERO;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("divider count exceeds n");

  property p_reset_val;
    $past(rst) |-> s_r.gen_ctl == CCS_GEN_CTL_RST
      && s_r.core_sel == CCS_SRC_SEL_RST[CCS_CORE_SEL_BIT];
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("reset value wrong");

  property p_reset_out;
    $past(rst) |-> reg_rdata == CCS_RDATA_RST && !pll_divider_output && !codec_core_clock
      && !clock_divider_input && !pll_reference_input;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("output set after reset");

  property p_wrap;
    pll_rise && s_r.cnt == nval - CCS_CNT_ONE && !reg_req.wr
      |=> s_r.cnt == CCS_CNT_ZERO && pll_divider_output;
  endproperty
  a_wrap: assert property (p_wrap) else $error("divider period wrong");

  // ----------------------------------------------------------------
  // register port checks
  // ----------------------------------------------------------------
  property p_sel_rd;
    reg_req.rd && reg_req.addr == CCS_SRC_SEL_ADDR |=> reg_rdata[CCS_CORE_SEL_BIT] == $past(s_r.core_sel);
  endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("select readback wrong");

  property p_gen_rd;
    reg_req.rd && reg_req.addr == CCS_GEN_CTL_ADDR |=> reg_rdata == $past(s_r.gen_ctl);
  endproperty
  a_gen_rd: assert property (p_gen_rd) else $error("control readback wrong");

  property p_gen_wr;
    reg_req.wr && reg_req.addr == CCS_GEN_CTL_ADDR |=> s_r.gen_ctl == $past(reg_req.wdata);
  endproperty
  a_gen_wr: assert property (p_gen_wr) else $error("control write lost");

  property p_gen_keep;
    !(reg_req.wr && reg_req.addr == CCS_GEN_CTL_ADDR) |=> $stable(s_r.gen_ctl);
  endproperty
  a_gen_keep: assert property (p_gen_keep) else $error("control changed unwritten");

  property p_sel_keep;
    !(reg_req.wr && reg_req.addr == CCS_SRC_SEL_ADDR) |=> $stable(s_r.core_sel);
  endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("select changed unwritten");

  // read data must stand between reads
  property p_rdata_hold;
    !reg_req.rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // ----------------------------------------------------------------
  // clock path checks
  // ----------------------------------------------------------------
  property p_core_pll;
    !s_r.core_sel |=> codec_core_clock == $past(pll_divider_output);
  endproperty
  a_core_pll: assert property (p_core_pll) else $error("core clock not pll path");

  property p_core_cdo;
    s_r.core_sel |=> codec_core_clock == $past(s_r.cdo_sync[1]);
  endproperty
  a_core_cdo: assert property (p_core_cdo) else $error("core clock not divider path");

  property p_nval_16;
    s_r.gen_ctl[CCS_NDIV_HI:CCS_NDIV_LO] == CCS_NCODE_16 |-> nval == CCS_NVAL_16;
  endproperty
  a_nval_16: assert property (p_nval_16) else $error("code zero not sixteen");

  property p_nval_17;
    s_r.gen_ctl[CCS_NDIV_HI:CCS_NDIV_LO] == CCS_NCODE_17 |-> nval == CCS_NVAL_17;
  endproperty
  a_nval_17: assert property (p_nval_17) else $error("code one not seventeen");

  property p_nval_own;
    s_r.gen_ctl[CCS_NDIV_HI:CCS_NDIV_LO] != CCS_NCODE_16
      && s_r.gen_ctl[CCS_NDIV_HI:CCS_NDIV_LO] != CCS_NCODE_17
      |-> nval == {1'b0, s_r.gen_ctl[CCS_NDIV_HI:CCS_NDIV_LO]};
  endproperty
  a_nval_own: assert property (p_nval_own) else $error("plain divide code wrong");

  property p_cnt_inc;
    pll_rise && s_r.cnt < nval - CCS_CNT_ONE |=> s_r.cnt == $past(s_r.cnt) + CCS_CNT_ONE;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("divider count skipped");

  // output may only move on a pll edge or a new divide value
  property p_pdo_stable;
    !$past(rst) && !pll_rise && $stable(s_r.gen_ctl) |=> $stable(pll_divider_output);
  endproperty
  a_pdo_stable: assert property (p_pdo_stable) else $error("divider output moved");

endmodule : ccs_clock_select

// ===== ccs_clock_select_tb.sv
// self-checking testbench for the codec clock source select block
// assumes ccs_pkg and ccs_clock_select are compiled before this file
`timescale 1ns/100ps
module codec_clock_source_select_tb_top;
  import ccs_pkg::*;
  logic mclk, rst, mpin, bpin, cdo;
  logic [2:0] ph = 3'h0;
  logic pll = 1'b0;
  ccs_reg_req_t req;
  logic [7:0] rdata;
  logic div_in, ref_in, pdo, core;
  int n_mismatch = 0;
  int num_checks = 0;

  ccs_clock_select ccs_clock_select_inst (.mclk(mclk), .rst(rst), .reg_req(req),
    .reg_rdata(rdata), .master_clk_pin(mpin), .bit_clk_pin(bpin), .pll_clock(pll),
    .clock_divider_output(cdo), .clock_divider_input(div_in),
    .pll_reference_input(ref_in), .pll_divider_output(pdo), .codec_core_clock(core));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // pll clock at one eighth of mclk, slow enough for the synchronisers
  always @(posedge mclk)
  begin
    ph <= ph + 3'h1;
    pll <= ph[2];
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 chk("reg_rdata", exp, rdata);
  endtask : rchk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rchk(8'h65, 8'h00);
    rchk(8'h66, 8'h02);
    wr(8'h65, 8'h01);
    rchk(8'h65, 8'h01);
    wr(8'h67, 8'h55);
    rchk(8'h64, 8'h00);
    rchk(8'h66, 8'h02);
    repeat (3) @(posedge mclk);
    #1 chk("reg_rdata hold", 8'h02, rdata);
    $display("test regs done");
  endtask : t_regs

  task automatic t_core();
    logic prev;
    @(posedge mclk);
    cdo <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 chk("core_clock", 8'h01, {7'h00, core});
    @(posedge mclk);
    cdo <= 1'b0;
    repeat (6) @(posedge mclk);
    #1 chk("core_clock", 8'h00, {7'h00, core});
    wr(8'h65, 8'h00);
    repeat (4) @(posedge mclk);
    #1 prev = pdo;
    repeat (40)
    begin
      @(posedge mclk);
      #1 chk("core_clock", {7'h00, prev}, {7'h00, core});
      prev = pdo;
    end
    $display("test core done");
  endtask : t_core

  task automatic t_src();
    logic [7:0] codes[4] = '{8'h02, 8'h82, 8'h22, 8'ha2};
    foreach (codes[i])
    begin
      wr(8'h66, codes[i]);
      for (int m = 0; m < 2; m++)
      begin
        @(posedge mclk);
        mpin <= m[0];
        bpin <= !m[0];
        repeat (6) @(posedge mclk);
        #1 chk("div_in", {7'h00, codes[i][7] ^ m[0]}, {7'h00, div_in});
        chk("ref_in", {7'h00, codes[i][5] ^ m[0]}, {7'h00, ref_in});
      end
    end
    $display("test sources done");
  endtask : t_src

  task automatic t_div();
    logic [7:0] codes[4] = '{8'h00, 8'h01, 8'h02, 8'h0f};
    logic [7:0] nval[4] = '{8'h10, 8'h11, 8'h02, 8'h0f};
    logic pl0, pd0;
    int rises;
    logic [7:0] n;
    foreach (codes[j])
    begin
      wr(8'h66, codes[j]);
      rises = 0;
      n = 8'h00;
      pl0 = pll;
      pd0 = pdo;
      // first output period after a change may be short, so measure the second
      for (int i = 0; i < 2000 && rises < 3; i++)
      begin
        @(posedge mclk);
        #1;
        if (pll && !pl0 && rises == 2)
          n = n + 8'h01;
        if (pdo && !pd0)
          rises++;
        pl0 = pll;
        pd0 = pdo;
      end
      chk("divide", nval[j], n);
    end
    $display("test divider done");
  endtask : t_div

  initial
  begin
    rst = 1'b1;
    req = '0;
    mpin = 1'b0;
    bpin = 1'b0;
    cdo = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_core();
    t_src();
    t_div();
    test_done();
  end

  initial
  begin
    // tests need under 2000 cycles; allow five times that
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule : codec_clock_source_select_tb_top
